// >>> logic/dbgag_gate.sv
// What this block does
// - value registers hold plain virtual addresses
// - vector catch uses vectors as virtual addresses
// - fault address adds 8 wide, 4 compact
// - bus and debug-domain registers survive core off
// - core reset clears only core-domain debug state
// - warm reset spares all debug state
// - debug reset clears all debug but sets both locks, no core logic
// - soft lock ignores writes except lock access
// - address bit 31 high overrides soft lock
// - os lock errors core-domain register accesses
// - locks kept in debug domain, debug reset only
// - reserved access under lock: either answer fine
// - powerdown request errors core-domain accesses
// - sticky set on powerdown, cleared by status read
// - sticky bit errors core-domain accesses
// - ident, event catch, run control, management always succeed
// - errored access drops write, read data undefined
// - power status, control, lock status always accessible
// - save/restore defined only powered, locked, not sticky
// - read-only ignores writes, write-only reads undefined
`timescale 1ns/10ps
`include "dbgag_consts.svh"

module dbgag_gate (
   input wire logic clk_i,                // bus clock
   input wire logic rst_b_i,              // debug reset, sync, low
   input wire logic core_por_b_i,         // core power-on reset, low
   input wire logic warm_rst_b_i,         // warm reset, low
   input wire logic [31:0] address,       // byte address, bit31 ext
   input wire logic read,                 // read request
   input wire logic write,                // write request
   input wire logic [31:0] writedata,     // write data
   input wire logic [3:0] byteenable,     // byte lanes
   output logic waitrequest,              // stall
   output logic [31:0] readdata,          // read data
   output logic [1:0] response,           // 0 ok, 2 slave error
   output logic slv_err_o,                // error flag with answer
   input wire logic core_pwrdn_req_i,     // core powerdown request
   input wire logic wp_hit_i,             // watchpoint hit pulse
   input wire logic [31:0] wp_va_i,       // faulting virtual address
   input wire logic wp_compact_i,         // 1 compact, 0 wide state
   output logic core_logic_rst_b_o,       // non-debug core reset
   output logic core_dbg_rst_b_o,         // core-domain debug reset
   output logic [5:0][31:0] break_value_o, // break values, va
   output logic [1:0][31:0] watch_value_o, // watch values, va
   output logic [31:0] vector_catch_o,    // vector catch enables
   output logic [31:0] event_catch_o,     // event catch
   output logic [31:0] pwrdn_ctrl_o,      // powerdown/reset control
   output logic run_ctrl_vld_o,           // run control write pulse
   output logic [31:0] run_ctrl_o,        // run control word
   output logic os_lock_o,                // os lock state
   output logic soft_lock_o,              // software lock state
   output logic sticky_pd_o               // sticky powerdown
);

   ////////////////////////////////////////////////////////////////////
   // decode

   function automatic dbgag_pkg::dbgag_class_t classify(
      input logic [11:0] off
   );
      dbgag_pkg::dbgag_class_t c;
      c = dbgag_pkg::DBGAG_C_RAZ;
      if (off > `DBGAG_OFF_OTHER_HI) begin
         if (off == `DBGAG_OFF_SLAR) begin
            c = dbgag_pkg::DBGAG_C_SLAR;
         end else if (off == `DBGAG_OFF_SLSR) begin
            c = dbgag_pkg::DBGAG_C_SLSR;
         end else begin
            c = dbgag_pkg::DBGAG_C_MGMT;
         end
      end else begin
         case (off)
            `DBGAG_OFF_IDENT: c = dbgag_pkg::DBGAG_C_IDENT;
            `DBGAG_OFF_EVCATCH: c = dbgag_pkg::DBGAG_C_EVCATCH;
            `DBGAG_OFF_RUNCTL: c = dbgag_pkg::DBGAG_C_RUNCTL;
            `DBGAG_OFF_OS_LOCK_ACCESS_REG: c = dbgag_pkg::DBGAG_C_OS_LOCK_ACCESS_REG;
            `DBGAG_OFF_OS_LOCK_STATUS_REG: c = dbgag_pkg::DBGAG_C_OS_LOCK_STATUS_REG;
            `DBGAG_OFF_OS_SAVE_RESTORE_REG: c = dbgag_pkg::DBGAG_C_OS_SAVE_RESTORE_REG;
            `DBGAG_OFF_PWRDOWN_RESET_CONTROL_REG: c = dbgag_pkg::DBGAG_C_PWRDOWN_RESET_CONTROL_REG;
            `DBGAG_OFF_PWRDOWN_RESET_STATUS_REG: c = dbgag_pkg::DBGAG_C_PWRDOWN_RESET_STATUS_REG;
            `DBGAG_OFF_WATCH_FAULT_ADDR_REG,
            `DBGAG_OFF_VCATCH: c = dbgag_pkg::DBGAG_C_CORE;
            default: begin
               if ((off >= `DBGAG_OFF_BVAL_LO &&
                    off <= `DBGAG_OFF_BVAL_HI) ||
                   (off >= `DBGAG_OFF_WVAL_LO &&
                    off <= `DBGAG_OFF_WVAL_HI)) begin
                  c = dbgag_pkg::DBGAG_C_CORE;
               end
            end
         endcase
      end
      return c;
   endfunction : classify

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////
   // state

   dbgag_pkg::dbgag_state_t state_r;
   dbgag_pkg::dbgag_state_t state_nxt;
   dbgag_pkg::dbgag_req_t req;
   dbgag_pkg::dbgag_class_t cls;
   logic [11:0] off;
   logic ext_acc;
   logic take;
   logic err;
   logic wr_ok;
   logic [2:0] bidx;
   logic widx;

   assign req.addr = address;
   assign req.rd = read;
   assign req.wr = write;
   assign req.wdata = writedata;
   assign req.be = byteenable;

   assign off = req.addr[11:0];
   assign ext_acc = req.addr[`DBGAG_ADDR_EXT_BIT];
   assign cls = classify(off);
   assign bidx = 3'(off[4:2]);
   assign widx = off[2];
   assign take = (req.rd | req.wr) & ~state_r.ack;

   // core-domain registers are gated by powerdown, os lock and sticky
   always_comb begin
      err = 1'b0;
      if (cls == dbgag_pkg::DBGAG_C_CORE) begin
         err = core_pwrdn_req_i | state_r.oslock |
               state_r.sticky;
      end
   end

   // soft lock blocks writes unless from the external debugger or to the lock access register
   assign wr_ok = req.wr & ~err &
                  (ext_acc | ~state_r.slock |
                   cls == dbgag_pkg::DBGAG_C_SLAR);

   always_comb begin
      state_nxt = state_r;
      state_nxt.runctl_vld = 1'b0;
      state_nxt.ack = take;
      // sticky set on every cycle of powerdown
      if (take && req.rd && cls == dbgag_pkg::DBGAG_C_PWRDOWN_RESET_STATUS_REG) begin
         state_nxt.sticky = 1'b0;
      end
      if (core_pwrdn_req_i) begin
         state_nxt.sticky = 1'b1;
      end
      // watchpoint hit captures fault address with state offset
      if (wp_hit_i) begin
         state_nxt.cmp.watch_fault_addr_reg = wp_va_i + (wp_compact_i ?
            `DBGAG_WATCH_FAULT_ADDR_REG_OFF_CMP : `DBGAG_WATCH_FAULT_ADDR_REG_OFF_WIDE);
      end
      if (take) begin
         state_nxt.resp = err ? `DBGAG_RESP_ERR : `DBGAG_RESP_OK;
         state_nxt.rdata = 32'h0000_0000;
         if (req.rd && !err) begin
            case (cls)
               dbgag_pkg::DBGAG_C_IDENT: state_nxt.rdata = `DBGAG_IDENT_VAL;
               dbgag_pkg::DBGAG_C_EVCATCH: state_nxt.rdata = state_r.evcatch;
               dbgag_pkg::DBGAG_C_OS_LOCK_STATUS_REG: begin
                  state_nxt.rdata[`DBGAG_OSL_BIT] = state_r.oslock;
               end
               dbgag_pkg::DBGAG_C_OS_SAVE_RESTORE_REG: begin
                  // defined only powered up, locked, no sticky
                  if (!core_pwrdn_req_i && state_r.oslock &&
                      !state_r.sticky) begin
                     state_nxt.rdata = state_r.os_save_restore_reg;
                  end
               end
               dbgag_pkg::DBGAG_C_PWRDOWN_RESET_CONTROL_REG: begin
                  state_nxt.rdata = state_r.pwrdown_reset_control_reg;
               end
               dbgag_pkg::DBGAG_C_PWRDOWN_RESET_STATUS_REG: begin
                  state_nxt.rdata[`DBGAG_PWRDOWN_RESET_STATUS_REG_PD_BIT] = core_pwrdn_req_i;
                  state_nxt.rdata[`DBGAG_PWRDOWN_RESET_STATUS_REG_STK_BIT] =
                     state_r.sticky;
               end
               dbgag_pkg::DBGAG_C_SLSR: begin
                  state_nxt.rdata[`DBGAG_SLK_IMPL_BIT] = 1'b1;
                  state_nxt.rdata[`DBGAG_SLK_BIT] = state_r.slock;
               end
               dbgag_pkg::DBGAG_C_CORE: begin
                  if (off == `DBGAG_OFF_WATCH_FAULT_ADDR_REG) begin
                     state_nxt.rdata = state_r.cmp.watch_fault_addr_reg;
                  end else if (off == `DBGAG_OFF_VCATCH) begin
                     state_nxt.rdata = state_r.cmp.vcatch;
                  end else if (off <= `DBGAG_OFF_BVAL_HI) begin
                     state_nxt.rdata = state_r.cmp.bval[bidx];
                  end else begin
                     state_nxt.rdata = state_r.cmp.wval[widx];
                  end
               end
               default: state_nxt.rdata = 32'h0000_0000;
            endcase
         end
         if (wr_ok) begin
            case (cls)
               dbgag_pkg::DBGAG_C_EVCATCH: begin
                  state_nxt.evcatch = merge(state_r.evcatch, req.wdata,
                                            req.be);
               end
               dbgag_pkg::DBGAG_C_RUNCTL: begin
                  state_nxt.runctl_vld = 1'b1;
                  state_nxt.runctl = req.wdata;
               end
               dbgag_pkg::DBGAG_C_OS_LOCK_ACCESS_REG: begin
                  state_nxt.oslock = req.wdata[0];
               end
               dbgag_pkg::DBGAG_C_OS_SAVE_RESTORE_REG: begin
                  if (!core_pwrdn_req_i && state_r.oslock &&
                      !state_r.sticky) begin
                     state_nxt.os_save_restore_reg = req.wdata;
                  end
               end
               dbgag_pkg::DBGAG_C_PWRDOWN_RESET_CONTROL_REG: begin
                  state_nxt.pwrdown_reset_control_reg = merge(state_r.pwrdown_reset_control_reg, req.wdata, req.be);
               end
               dbgag_pkg::DBGAG_C_SLAR: begin
                  state_nxt.slock = (req.wdata != `DBGAG_SLK_KEY);
               end
               dbgag_pkg::DBGAG_C_CORE: begin
                  if (off == `DBGAG_OFF_WATCH_FAULT_ADDR_REG) begin
                     state_nxt.cmp.watch_fault_addr_reg = merge(state_r.cmp.watch_fault_addr_reg,
                                                req.wdata, req.be);
                  end else if (off == `DBGAG_OFF_VCATCH) begin
                     state_nxt.cmp.vcatch = merge(state_r.cmp.vcatch,
                                                  req.wdata, req.be);
                  end else if (off <= `DBGAG_OFF_BVAL_HI) begin
                     state_nxt.cmp.bval[bidx] = merge(
                        state_r.cmp.bval[bidx], req.wdata, req.be);
                  end else begin
                     state_nxt.cmp.wval[widx] = merge(
                        state_r.cmp.wval[widx], req.wdata, req.be);
                  end
               end
               default: state_nxt.runctl_vld = 1'b0;
            endcase
         end
      end
      // core power-on reset clears only core-domain debug state
      if (!core_por_b_i) begin
         state_nxt.cmp = '0;
         state_nxt.os_save_restore_reg = 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers; debug reset clears all debug state but sets both locks, warm reset none

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_r <= '0;
         state_r.slock <= 1'b1;
         state_r.oslock <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign waitrequest = (req.rd | req.wr) & ~state_r.ack;
   assign readdata = state_r.rdata;
   assign response = state_r.resp;
   assign slv_err_o = state_r.resp == `DBGAG_RESP_ERR;
   assign core_logic_rst_b_o = core_por_b_i & warm_rst_b_i;
   assign core_dbg_rst_b_o = core_por_b_i & rst_b_i;
   assign break_value_o = state_r.cmp.bval;
   assign watch_value_o = state_r.cmp.wval;
   assign vector_catch_o = state_r.cmp.vcatch;
   assign event_catch_o = state_r.evcatch;
   assign pwrdn_ctrl_o = state_r.pwrdown_reset_control_reg;
   assign run_ctrl_vld_o = state_r.runctl_vld;
   assign run_ctrl_o = state_r.runctl;
   assign os_lock_o = state_r.oslock;
   assign soft_lock_o = state_r.slock;
   assign sticky_pd_o = state_r.sticky;

endmodule : dbgag_gate

// >>> shared/dbgag_consts.svh
`ifndef DBGAG_CONSTS_SVH
`define DBGAG_CONSTS_SVH

// register offsets inside the 4 KB window
`define DBGAG_OFF_IDENT     12'h000
`define DBGAG_OFF_WATCH_FAULT_ADDR_REG      12'h018
`define DBGAG_OFF_VCATCH    12'h01c
`define DBGAG_OFF_EVCATCH   12'h024
`define DBGAG_OFF_RUNCTL    12'h090
`define DBGAG_OFF_BVAL_LO   12'h100
`define DBGAG_OFF_BVAL_HI   12'h114
`define DBGAG_OFF_WVAL_LO   12'h180
`define DBGAG_OFF_WVAL_HI   12'h184
`define DBGAG_OFF_OS_LOCK_ACCESS_REG     12'h300
`define DBGAG_OFF_OS_LOCK_STATUS_REG     12'h304
`define DBGAG_OFF_OS_SAVE_RESTORE_REG     12'h308
`define DBGAG_OFF_PWRDOWN_RESET_CONTROL_REG      12'h310
`define DBGAG_OFF_PWRDOWN_RESET_STATUS_REG      12'h314
`define DBGAG_OFF_OTHER_HI  12'hf00
`define DBGAG_OFF_SLAR      12'hfb0
`define DBGAG_OFF_SLSR      12'hfb4

// field positions
`define DBGAG_OSL_BIT       1
`define DBGAG_SLK_BIT       1
`define DBGAG_SLK_IMPL_BIT  0
`define DBGAG_PWRDOWN_RESET_STATUS_REG_PD_BIT   0
`define DBGAG_PWRDOWN_RESET_STATUS_REG_STK_BIT  1
`define DBGAG_ADDR_EXT_BIT  31

// values
`define DBGAG_SLK_KEY       32'h5a5a_a5a5
`define DBGAG_IDENT_VAL     32'h0000_0001
`define DBGAG_WATCH_FAULT_ADDR_REG_OFF_WIDE 32'h0000_0008
`define DBGAG_WATCH_FAULT_ADDR_REG_OFF_CMP  32'h0000_0004
`define DBGAG_RESP_OK       2'h0
`define DBGAG_RESP_ERR      2'h2
`define DBGAG_N_BVAL        6
`define DBGAG_N_WVAL        2

`endif

// >>> shared/dbgag_pkg.sv
package dbgag_pkg;

   typedef enum logic [3:0] {
      DBGAG_C_IDENT,
      DBGAG_C_EVCATCH,
      DBGAG_C_RUNCTL,
      DBGAG_C_CORE,
      DBGAG_C_OS_LOCK_ACCESS_REG,
      DBGAG_C_OS_LOCK_STATUS_REG,
      DBGAG_C_OS_SAVE_RESTORE_REG,
      DBGAG_C_PWRDOWN_RESET_CONTROL_REG,
      DBGAG_C_PWRDOWN_RESET_STATUS_REG,
      DBGAG_C_SLAR,
      DBGAG_C_SLSR,
      DBGAG_C_MGMT,
      DBGAG_C_RAZ
   } dbgag_class_t;

   typedef struct packed {
      logic [31:0] addr;
      logic rd;
      logic wr;
      logic [31:0] wdata;
      logic [3:0] be;
   } dbgag_req_t;

   typedef struct packed {
      logic [5:0][31:0] bval;
      logic [1:0][31:0] wval;
      logic [31:0] vcatch;
      logic [31:0] watch_fault_addr_reg;
   } dbgag_cmp_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [31:0] evcatch;
      logic [31:0] pwrdown_reset_control_reg;
      logic oslock;
      logic slock;
      logic sticky;
      logic [31:0] os_save_restore_reg;
      logic runctl_vld;
      logic [31:0] runctl;
      dbgag_cmp_t cmp;
   } dbgag_state_t;

endpackage : dbgag_pkg

// >>> tb/dbgag_gate_monitor.sv
`timescale 1ns/10ps
module dbgag_gate_monitor (
   input wire logic clk_i, // clock
   input wire logic rst_b_i, // debug reset
   input wire logic core_por_b_i, // core reset
   input wire logic warm_rst_b_i, // warm reset
   input wire logic [31:0] address, // address
   input wire logic read, // read
   input wire logic write, // write
   input wire logic [31:0] writedata, // data
   input wire logic [3:0] byteenable, // lanes
   input wire logic waitrequest, // stall
   input wire logic [1:0] response, // response
   input wire logic slv_err_o, // error flag
   input wire logic core_pwrdn_req_i, // powerdown
   input wire logic core_logic_rst_b_o, // core reset out
   input wire logic core_dbg_rst_b_o, // core debug reset
   input wire logic [31:0] event_catch_o, // event catch
   input wire logic os_lock_o, // os lock
   input wire logic soft_lock_o, // soft lock
   input wire logic sticky_pd_o, // sticky
   input wire logic run_ctrl_vld_o // run control pulse
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [11:0] off;
   logic take;
   logic core_hit;
   logic safe;
   assign off = address[11:0];
   assign take = (read || write) && waitrequest;
   assign core_hit = off inside {12'h018, 12'h01c, 12'h100, 12'h104,
      12'h108, 12'h10c, 12'h110, 12'h114, 12'h180, 12'h184};
   assign safe = off inside {12'h000, 12'h024, 12'h090, 12'h304,
      12'h310, 12'h314} || off >= 12'hf04;
   ////////////////////////////////////////////////////////////////////////
   err_flag_a: assert property (
      !waitrequest |-> slv_err_o == (response == 2'h2))
      else $error("error flag differs from response");
   one_wait_a: assert property (take |=> !waitrequest)
      else $error("answer not one cycle after request");
   pd_err_a: assert property (
      take && core_pwrdn_req_i && core_hit |=> response == 2'h2)
      else $error("core access during powerdown not refused");
   osl_err_a: assert property (
      take && os_lock_o && core_hit |=> response == 2'h2)
      else $error("core access under os lock not refused");
   stk_err_a: assert property (
      take && sticky_pd_o && core_hit |=> response == 2'h2)
      else $error("core access with sticky set not refused");
   always_ok_a: assert property (
      take && safe |=> response == 2'h0)
      else $error("always accessible register refused");
   sticky_keep_a: assert property (
      (core_pwrdn_req_i || sticky_pd_o) && !(take && read && off == 12'h314)
      |=> sticky_pd_o)
      else $error("sticky flag lost");
   lock_keep_a: assert property (
      !(take && write && (off == 12'h300 || off == 12'hfb0))
      |=> $stable(os_lock_o) && $stable(soft_lock_o))
      else $error("lock changed without lock write");
   ext_wr_a: assert property (
      take && write && address[31] && off == 12'h024 && byteenable == 4'hf
      |=> event_catch_o == $past(writedata))
      else $error("debugger write not applied");
   slk_drop_a: assert property (
      take && write && soft_lock_o && !address[31] && off == 12'h024
      |=> $stable(event_catch_o))
      else $error("locked write applied");
   rst_map_a: assert property (
      core_dbg_rst_b_o == (core_por_b_i && rst_b_i) &&
      core_logic_rst_b_o == (core_por_b_i && warm_rst_b_i))
      else $error("reset outputs wrong");
   ctl_pulse_a: assert property (
      run_ctrl_vld_o == $past(take && write && off == 12'h090 &&
      (address[31] || !soft_lock_o)))
      else $error("run control pulse wrong");
endmodule : dbgag_gate_monitor

bind dbgag_gate dbgag_gate_monitor u_mon (.clk_i, .rst_b_i, .core_por_b_i,
   .warm_rst_b_i, .address, .read, .write, .writedata, .byteenable,
   .waitrequest, .response, .slv_err_o, .core_pwrdn_req_i,
   .core_logic_rst_b_o, .core_dbg_rst_b_o, .event_catch_o, .os_lock_o,
   .soft_lock_o, .sticky_pd_o, .run_ctrl_vld_o);

// >>> tb/dbgag_master.sv
`timescale 1ns/10ps
module dbgag_master (
   input wire logic clk_i, // clock
   input wire logic rst_b_i, // reset
   input wire logic go_i, // command valid
   input wire dbgag_pkg::dbgag_req_t cmd_i, // command
   output logic acc_o, // command taken
   output logic done_o, // answer pulse
   output logic [31:0] rdata_o, // read data
   output logic [1:0] resp_o, // response
   output dbgag_pkg::dbgag_req_t bus_o, // bus request
   input wire logic waitrequest, // stall
   input wire logic [31:0] readdata, // read data
   input wire logic [1:0] response // response
);
   logic busy_r;
   logic fin;
   assign fin = busy_r && !waitrequest;
   // debugger or software traffic is issued, bit 31 as commanded
   always_ff @(posedge clk_i) begin
      acc_o <= 1'b0;
      done_o <= fin;
      if (fin) begin
         rdata_o <= readdata;
         resp_o <= response;
      end
      if (!rst_b_i) begin
         busy_r <= 1'b0;
         bus_o <= '0;
      end else if (go_i && !acc_o && (!busy_r || fin)) begin
         busy_r <= 1'b1;
         bus_o <= cmd_i; // bit 31 set as commanded
         acc_o <= 1'b1;
      end else if (fin) begin
         busy_r <= 1'b0;
         bus_o.rd <= 1'b0;
         bus_o.wr <= 1'b0;
         bus_o.addr <= ~bus_o.addr;
         bus_o.wdata <= ~bus_o.wdata;
      end
   end
endmodule : dbgag_master

// >>> tb/dbgag_gate_bench.sv
`timescale 1ns/10ps
module dbgag_gate_bench;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic por_b = 1'b1;
   logic warm_b = 1'b1;
   logic pd_req = 1'b0;
   logic hit = 1'b0;
   logic cpt = 1'b0;
   logic go = 1'b0;
   logic [31:0] va = 32'h0;
   logic [31:0] seed = 32'hcb7a5b41;
   logic [31:0] d;
   logic [31:0] k0;
   logic [31:0] a;
   logic [31:0] rdat, brd, ec, rc;
   logic [1:0] resp, bresp;
   logic acc, done, wreq, vld, crst, drst;
   logic [5:0][31:0] bv;
   logic [1:0][31:0] wv;
   logic [31:0] vc, pc;
   dbgag_pkg::dbgag_req_t cmd = '0;
   dbgag_pkg::dbgag_req_t bus;
   int err_count = 0;
   int cmp_count = 0;
   int i;
   always #2.5 clk_i = ~clk_i;
   dbgag_gate u_dut (.clk_i, .rst_b_i, .core_por_b_i(por_b),
      .warm_rst_b_i(warm_b), .address(bus.addr), .read(bus.rd),
      .write(bus.wr), .writedata(bus.wdata), .byteenable(bus.be),
      .waitrequest(wreq), .readdata(brd), .response(bresp), .slv_err_o(),
      .core_pwrdn_req_i(pd_req), .wp_hit_i(hit), .wp_va_i(va),
      .wp_compact_i(cpt), .core_logic_rst_b_o(crst),
      .core_dbg_rst_b_o(drst), .break_value_o(bv), .watch_value_o(wv),
      .vector_catch_o(vc), .event_catch_o(ec), .pwrdn_ctrl_o(pc),
      .run_ctrl_vld_o(vld), .run_ctrl_o(rc), .os_lock_o(),
      .soft_lock_o(), .sticky_pd_o());
   dbgag_master u_host (.clk_i, .rst_b_i, .go_i(go), .cmd_i(cmd),
      .acc_o(acc), .done_o(done), .rdata_o(rdat), .resp_o(resp),
      .bus_o(bus), .waitrequest(wreq), .readdata(brd), .response(bresp));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [31:0] watch_fault_addr_reg_exp(logic [31:0] v, logic c);
      return v + (c ? 32'h4 : 32'h8);
   endfunction : watch_fault_addr_reg_exp
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(bit dn);
      int k;
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while ((dn ? done : acc) !== 1'b1 && k < 60);
      if (k >= 60) begin
         err_count++;
         report_and_stop();
      end
   endtask : wt
   task automatic issue(logic [31:0] ad, logic w, logic [31:0] dt);
      @(posedge clk_i);
      go <= 1'b1;
      cmd <= '{addr: ad, rd: !w, wr: w, wdata: dt, be: 4'hf};
      wt(1'b0);
   endtask : issue
   task automatic fin();
      @(posedge clk_i);
      go <= 1'b0;
      wt(1'b1);
   endtask : fin
   // access, then compare response and, for good reads, data
   task automatic op(logic [31:0] ad, logic w, logic [31:0] dt,
                     logic [31:0] e, logic [1:0] r);
      issue(ad, w, dt);
      fin();
      chk({30'h0, resp}, {30'h0, r});
      if (!w && r == 2'h0) chk(rdat, e);
   endtask : op
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4000) @(posedge clk_i);
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      op(32'h000, 1'b0, 32'h0, 32'h1, 2'h0);
      op(32'hfb4, 1'b0, 32'h0, 32'h3, 2'h0);
      op(32'h018, 1'b0, 32'h0, 32'h0, 2'h2);
      op(32'hf04, 1'b0, 32'h0, 32'h0, 2'h0);
      op(32'h300, 1'b1, 32'h0, 32'h0, 2'h0);
      op(32'h304, 1'b0, 32'h0, 32'h2, 2'h0);
      chk({31'h0, rdat[1]}, 32'h1);
      op(32'h8000_0300, 1'b1, 32'h0, 32'h0, 2'h0);
      op(32'h304, 1'b0, 32'h0, 32'h0, 2'h0);
      chk({31'h0, rdat[1]}, 32'h0);
      op(32'hfb0, 1'b1, 32'h5a5a_a5a5, 32'h0, 2'h0);
      op(32'hfb4, 1'b0, 32'h0, 32'h1, 2'h0);
      $display("test 1 done");
      for (i = 0; i < 9; i++) begin
         d = rnd();
         a = i == 8 ? 32'h01c : i < 6 ? 32'h100 + 4 * i : 32'h168 + 4 * i;
         if (i == 0) k0 = d;
         op(a, 1'b1, d, 32'h0, 2'h0);
         op(a, 1'b0, 32'h0, d, 2'h0);
         if (i < 6) chk(bv[i], d);
         if (i == 6 || i == 7) chk(wv[i - 6], d);
         if (i == 8) chk(vc, d);
      end
      for (i = 0; i < 2; i++) begin
         @(posedge clk_i);
         hit <= 1'b1;
         va <= rnd();
         cpt <= i[0];
         @(posedge clk_i);
         hit <= 1'b0;
         op(32'h018, 1'b0, 32'h0, watch_fault_addr_reg_exp(va, cpt), 2'h0);
      end
      d = rnd();
      op(32'h090, 1'b1, d, 32'h0, 2'h0);
      chk(rc, d);
      op(32'h024, 1'b1, d, 32'h0, 2'h0);
      chk(ec, d);
      $display("test 2 done");
      @(posedge clk_i);
      pd_req <= 1'b1;
      op(32'h100, 1'b0, 32'h0, 32'h0, 2'h2);
      op(32'h100, 1'b1, ~k0, 32'h0, 2'h2);
      op(32'h024, 1'b0, 32'h0, d, 2'h0);
      op(32'h310, 1'b0, 32'h0, 32'h0, 2'h0);
      op(32'h310, 1'b1, d, 32'h0, 2'h0);
      chk(pc, d);
      op(32'h310, 1'b0, 32'h0, d, 2'h0);
      @(posedge clk_i);
      pd_req <= 1'b0;
      op(32'h01c, 1'b0, 32'h0, 32'h0, 2'h2);
      issue(32'h314, 1'b0, 32'h0);
      issue(32'h314, 1'b0, 32'h0);
      chk(rdat, 32'h2);
      fin();
      chk(rdat, 32'h0);
      op(32'h100, 1'b0, 32'h0, k0, 2'h0);
      op(32'h300, 1'b1, 32'h1, 32'h0, 2'h0);
      op(32'h01c, 1'b1, 32'h0, 32'h0, 2'h2);
      op(32'h300, 1'b1, 32'h0, 32'h0, 2'h0);
      $display("test 3 done");
      @(posedge clk_i);
      warm_b <= 1'b0;
      @(negedge clk_i);
      chk({30'h0, crst, drst}, 32'h1);
      @(posedge clk_i);
      por_b <= 1'b0;
      warm_b <= 1'b1;
      @(negedge clk_i);
      chk({30'h0, crst, drst}, 32'h0);
      @(posedge clk_i);
      por_b <= 1'b1;
      op(32'h100, 1'b0, 32'h0, 32'h0, 2'h0);
      op(32'h024, 1'b0, 32'h0, d, 2'h0);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      op(32'h024, 1'b0, 32'h0, 32'h0, 2'h0);
      op(32'hfb4, 1'b0, 32'h0, 32'h3, 2'h0);
      op(32'h024, 1'b1, d, 32'h0, 2'h0);
      op(32'h024, 1'b0, 32'h0, 32'h0, 2'h0);
      op(32'h8000_0024, 1'b1, d, 32'h0, 2'h0);
      op(32'h024, 1'b0, 32'h0, d, 2'h0);
      $display("test 4 done");
      report_and_stop();
   end
endmodule : dbgag_gate_bench
